// file: rcs_rx_client.sv
// Receive client stream: framing, padding removal, frame checks, AHB-Lite config
`default_nettype none
module rcs_rx_client (
	input  wire logic                     sys_clk_in,   // System clock
	input  wire logic                     rst_in,       // Sync reset, active high
	input  wire logic                     rx_rst_n_in,  // Receive path reset, active low
	input  wire rcs_pkg::rcs_rx_word_type rx_word_in,   // Decoded receive words
	input  wire rcs_pkg::rcs_fc_type      fc_in,        // Flow control verdict at eof
	output var  rcs_pkg::rcs_axis_type    rx_axis_out,  // Client stream
	input  wire logic                     hsel_in,      // AHB slave select
	input  wire logic [31:0]              haddr_in,     // AHB address
	input  wire logic [1:0]               htrans_in,    // AHB transfer type
	input  wire logic                     hwrite_in,    // AHB write
	input  wire logic [2:0]               hsize_in,     // AHB size, words only
	input  wire logic [31:0]              hwdata_in,    // AHB write data
	input  wire logic                     hready_in,    // AHB bus ready
	output logic                          hreadyout_out, // AHB slave ready
	output logic                          hresp_out,    // AHB response
	output logic [31:0]                   hrdata_out    // AHB read data
);
	import rcs_pkg::*;

	//==============================================================
	// Declarations
	rcs_state_type   state_reg;
	rcs_state_type   state_next;
	rcs_rx_word_type w;
	rcs_axis_type    out_reg;
	rcs_axis_type    out_next;
	rcs_axis_type    p_reg;
	rcs_axis_type    p_next;
	rcs_axis_type    cand_beat;
	logic            rx_rst;
	logic [31:0]     ctrl_reg;
	logic [31:0]     mtu_reg;
	logic [31:0]     good_cnt_reg;
	logic [31:0]     bad_cnt_reg;
	logic [31:0]     rdata_reg;
	logic            wr_pend_reg;
	logic [7:0]      wr_addr_reg;
	logic [15:0]     frame_bytes_reg;
	logic [15:0]     bytes_next;
	logic [16:0]     bytes_sum;
	logic [31:0]     crc_reg;
	logic [31:0]     crc_next;
	logic [15:0]     type_off_reg;
	logic [15:0]     type_val_reg;
	logic            type_seen_reg;
	logic [3:0]      tags_reg;
	logic            strip_on_reg;
	logic [15:0]     thr_reg;
	logic            err_reg;
	logic [31:0]     h_data_reg;
	logic [15:0]     h_off_reg;
	logic            h_full_reg;
	logic [31:0]     cand_data;
	logic [3:0]      cand_keep;
	logic [15:0]     cand_off;
	logic            cand_v;
	logic            cand_pre;
	logic            cand_nz;
	logic            tail_trim;
	logic            fin;
	logic [15:0]     tf;
	logic            is_tag;
	logic [3:0]      tag_lim;
	logic            strip_ok;
	logic            frame_bad;
	logic [15:0]     max_len;
	logic [15:0]     hdr_end;
	logic [16:0]     need_bytes;
	logic            len_applies;
	logic            is_ctrl;
	logic            addr_phase;

	//==============================================================
	// Helper functions
	function automatic logic [2:0] lane_count(input logic [3:0] k);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < LANES; i++)
		begin
			n = n + {2'h0, k[i]};
		end
		return n;
	endfunction

	// Reflected CRC-32 over the qualified lanes, lane 0 first
	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d,
		input logic [3:0] k);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < LANES; i++)
		begin
			if (k[i])
			begin
				for (int b = 0; b < LANE_W; b++)
				begin
					r = (r[0] ^ d[LANE_W * i + b]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
				end
			end
		end
		return r;
	endfunction

	//==============================================================
	// Receive path reset
	assign w = rx_word_in;
	assign rx_rst = rst_in | ~rx_rst_n_in;

	//==============================================================
	// AHB-Lite slave, zero wait state, always OKAY
	assign addr_phase    = hsel_in & htrans_in[1] & hready_in;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = rdata_reg;

	// Address phase capture; read data ready for the data phase
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= ADDR_CTRL;
			rdata_reg   <= WORD_ZERO;
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite_in;
			if (addr_phase)
			begin
				wr_addr_reg <= haddr_in[ADDR_W-1:0];
				unique case (haddr_in[ADDR_W-1:0])
					ADDR_CTRL: rdata_reg <= ctrl_reg;
					ADDR_MTU:  rdata_reg <= mtu_reg;
					ADDR_GOOD: rdata_reg <= good_cnt_reg;
					ADDR_BAD:  rdata_reg <= bad_cnt_reg;
					default:   rdata_reg <= WORD_ZERO;
				endcase
			end
		end
	end

	// Config writes land in the data phase
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ctrl_reg <= CTRL_RESET;
			mtu_reg  <= MTU_RESET;
		end
		else if (wr_pend_reg)
		begin
			if (wr_addr_reg == ADDR_CTRL)
				ctrl_reg <= hwdata_in & CTRL_MASK;
			if (wr_addr_reg == ADDR_MTU)
				mtu_reg <= hwdata_in & MTU_MASK;
		end
	end

	// Frame verdict counters, wrap silently
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			good_cnt_reg <= WORD_ZERO;
			bad_cnt_reg  <= WORD_ZERO;
		end
		else if (out_next.tvalid && out_next.tlast)
		begin
			if (out_next.tuser)
				good_cnt_reg <= good_cnt_reg + WORD_ONE;
			else
				bad_cnt_reg <= bad_cnt_reg + WORD_ONE;
		end
	end

	//==============================================================
	// Header parsing terms
	assign tf        = {w.data[LANE_W-1:0], w.data[2*LANE_W-1:LANE_W]};
	// both TPIDs, up to eight tags
	assign is_tag    = (tf == TPID_VLAN) || (ctrl_reg[CTRL_QINQ] && (tf == TPID_QINQ));
	assign tag_lim   = ctrl_reg[CTRL_QINQ] ? TAGS_QINQ : TAGS_ONE;
	// tagged frames keep padding by default
	assign strip_ok  = ctrl_reg[CTRL_LEN_CHK] && (tf < TYPE_MIN) && !ctrl_reg[CTRL_FCS_PASS]
		&& ((tags_reg == TAGS_ZERO) || ctrl_reg[CTRL_VLAN_LEN]);
	assign bytes_sum = {1'b0, frame_bytes_reg} + {14'h0000, lane_count(w.keep)};
	assign bytes_next = bytes_sum[16] ? BYTES_MAX : bytes_sum[15:0];
	assign crc_next  = crc_word(crc_reg, w.data, w.keep);

	// Per-frame tracking: byte count, CRC, type fields, line errors
	always_ff @(posedge sys_clk_in)
	begin
		if (rx_rst)
		begin
			frame_bytes_reg <= BYTES_ZERO;
			crc_reg         <= CRC_INIT;
			type_off_reg    <= TYPE_OFF_FIRST;
			type_val_reg    <= BYTES_ZERO;
			type_seen_reg   <= 1'b0;
			tags_reg        <= TAGS_ZERO;
			strip_on_reg    <= 1'b0;
			thr_reg         <= BYTES_ZERO;
			err_reg         <= 1'b0;
		end
		else if ((state_reg == ST_IDLE) && w.valid && w.sof)
		begin
			frame_bytes_reg <= BYTES_ZERO;
			crc_reg         <= CRC_INIT;
			type_off_reg    <= TYPE_OFF_FIRST;
			type_val_reg    <= BYTES_ZERO;
			type_seen_reg   <= 1'b0;
			tags_reg        <= TAGS_ZERO;
			strip_on_reg    <= 1'b0;
			err_reg         <= w.err;
		end
		else if ((state_reg == ST_PRE) && w.valid)
			err_reg <= err_reg | w.err;
		else if ((state_reg == ST_BODY) && w.valid)
		begin
			frame_bytes_reg <= bytes_next;
			crc_reg         <= crc_next;
			// line errors stick for the frame
			err_reg         <= err_reg | w.err;
			if (!type_seen_reg && (frame_bytes_reg == type_off_reg))
			begin
				if (is_tag && (tags_reg < tag_lim))
				begin
					tags_reg     <= tags_reg + TAGS_ONE;
					type_off_reg <= type_off_reg + TAG_BYTES;
				end
				else
				begin
					type_seen_reg <= 1'b1;
					type_val_reg  <= tf;
					strip_on_reg  <= strip_ok;
					thr_reg       <= type_off_reg + TYPE_BYTES + tf;
				end
			end
			if (w.eof)
				strip_on_reg <= 1'b0;
		end
	end

	// One-word hold so the FCS can be cut once eof reveals it
	always_ff @(posedge sys_clk_in)
	begin
		if (rx_rst || (state_reg == ST_IDLE))
		begin
			h_data_reg <= WORD_ZERO;
			h_off_reg  <= BYTES_ZERO;
			h_full_reg <= 1'b0;
		end
		else if ((state_reg == ST_BODY) && w.valid)
		begin
			h_data_reg <= w.data;
			h_off_reg  <= frame_bytes_reg;
			h_full_reg <= !w.eof && !ctrl_reg[CTRL_FCS_PASS];
		end
	end

	//==============================================================
	// Candidate beat: preamble, pass-through word, or held word
	always_comb
	begin
		cand_v    = 1'b0;
		cand_pre  = 1'b0;
		cand_data = w.data;
		cand_keep = LANES_NONE;
		cand_off  = frame_bytes_reg;
		tail_trim = 1'b0;
		fin       = 1'b0;
		unique case (state_reg)
			ST_IDLE, ST_PRE:
			begin
				if (w.valid && ctrl_reg[CTRL_CUST_PRE] && ((state_reg == ST_PRE) || w.sof))
				begin
					cand_v    = 1'b1;
					cand_pre  = 1'b1;
					cand_keep = LANES_ALL;
				end
			end
			ST_BODY:
			begin
				if (w.valid)
				begin
					fin = w.eof;
					if (ctrl_reg[CTRL_FCS_PASS])
					begin
						cand_v    = 1'b1;
						cand_keep = w.keep;
					end
					else
					begin
						cand_v    = h_full_reg;
						cand_data = h_data_reg;
						cand_off  = h_off_reg;
						cand_keep = LANES_ALL;
						tail_trim = w.eof;
					end
				end
			end
			ST_TAIL:
			begin
				cand_v = 1'b0;
			end
		endcase
		// lane i gates bits of byte i
		for (int i = 0; i < LANES; i++)
		begin
			if (!cand_pre && strip_on_reg && ((cand_off + 16'(i)) >= thr_reg))
				cand_keep[i] = 1'b0;
			if (tail_trim && (3'(i) >= lane_count(w.keep)))
				cand_keep[i] = 1'b0;
		end
		cand_nz = cand_v && (cand_keep != LANES_NONE);
	end

	//==============================================================
	// Frame checks, valid in the eof cycle
	always_comb
	begin
		is_ctrl     = type_seen_reg && (type_val_reg == TYPE_CONTROL);
		hdr_end     = type_off_reg + TYPE_BYTES;
		need_bytes  = {1'b0, hdr_end} + {1'b0, type_val_reg} + {1'b0, FCS_BYTES};
		len_applies = ctrl_reg[CTRL_LEN_CHK] && type_seen_reg && (type_val_reg < TYPE_MIN)
			&& ((tags_reg == TAGS_ZERO) || ctrl_reg[CTRL_VLAN_LEN]) && !is_ctrl;
		max_len     = (tags_reg != TAGS_ZERO) ? MAX_TAGGED : MAX_UNTAGGED;
		// MTU below the legal maximum is not guarded
		if (ctrl_reg[CTRL_MTU_EN])
			max_len = mtu_reg[MTU_W-1:0];
		frame_bad = 1'b0;
		if ((crc_next != CRC_RESIDUE) || (bytes_next < MIN_FRAME) || err_reg || w.err)
			frame_bad = 1'b1;
		if (!ctrl_reg[CTRL_JUMBO] && (bytes_next > max_len))
			frame_bad = 1'b1;
		if (len_applies && (type_val_reg < LEN_PAD_MIN) && (bytes_next != MIN_FRAME))
			frame_bad = 1'b1;
		if (len_applies && (type_val_reg >= LEN_PAD_MIN) && ({1'b0, bytes_next} < need_bytes))
			frame_bad = 1'b1;
		// control frames must be minimum size
		if (is_ctrl && !ctrl_reg[CTRL_CTL_DIS] && (bytes_next != MIN_FRAME))
			frame_bad = 1'b1;
		if ((ctrl_reg[CTRL_FC_EN] && fc_in.pause_hit) || (ctrl_reg[CTRL_PFC_EN] && fc_in.pfc_hit))
			frame_bad = 1'b1;
	end

	//==============================================================
	// Pending beat and output selection
	always_comb
	begin
		state_next       = state_reg;
		out_next         = BEAT_IDLE;
		p_next           = p_reg;
		cand_beat        = BEAT_IDLE;
		cand_beat.tdata  = cand_data;
		cand_beat.tkeep  = cand_keep;
		cand_beat.tvalid = 1'b1;
		cand_beat.tlast  = fin;
		// status high only for good frame
		cand_beat.tuser  = fin && !frame_bad;
		unique case (state_reg)
			ST_IDLE: if (w.valid && w.sof) state_next = ST_PRE;
			ST_PRE:  if (w.valid) state_next = ST_BODY;
			ST_BODY: if (fin) state_next = cand_nz ? ST_TAIL : ST_IDLE;
			ST_TAIL: state_next = ST_IDLE;
		endcase
		// close the frame before the next sof
		if (state_reg == ST_TAIL)
		begin
			out_next = p_reg;
			p_next   = BEAT_IDLE;
		end
		else if (fin && !cand_nz)
		begin
			// never end with an empty beat
			out_next = p_reg;
			if (!p_reg.tvalid)
			begin
				out_next.tdata  = WORD_ZERO;
				out_next.tkeep  = LANES_FIRST;
				out_next.tvalid = 1'b1;
			end
			// last and status with final bytes
			out_next.tlast = 1'b1;
			out_next.tuser = !frame_bad;
			p_next         = BEAT_IDLE;
		end
		// a beat leaves as the next one arrives
		else if (cand_nz)
		begin
			out_next = p_reg;
			p_next   = cand_beat;
		end
	end

	// Sequencer, pending beat and registered client outputs
	always_ff @(posedge sys_clk_in)
	begin
		if (rx_rst)
		begin
			state_reg <= ST_IDLE;
			p_reg     <= BEAT_IDLE;
			out_reg   <= BEAT_IDLE;
		end
		else
		begin
			state_reg <= state_next;
			p_reg     <= p_next;
			out_reg   <= out_next;
		end
	end

	// data and keep straight from flops
	assign rx_axis_out = out_reg;
endmodule
`default_nettype wire

// file: rcs_pkg.sv
// Constants, types and register map for the receive client stream block
//==============================================================
// Notes on behaviour
// - 32-bit data with four lane qualifiers
// - Qualifier bit n marks data byte n
// - Beats back to back except over withheld bytes, and between custom preamble beats unless FCS passing
// - Last flag one cycle, after all checks
// - Status high good, low bad
// - Final beat carries at least one byte
// - Bytes beyond length field are withheld
// - Short length needs exact 64-byte frame
// - End of frame before next data
// - FCS error, runt, line error mark bad
// - Oversize bad; MTU replaces limit when enabled
// - Data shorter than length field is bad
// - Control frame not minimum size is bad
// - Consumed pause or PFC frames marked bad
// - FCS passing forwards padding, still checks
// - Custom preamble on first two beats
// - Stacked tags, both TPIDs, eight headers
// - Tagged frames untouched unless tag checking
// - Legal maximum 1518 or 1522 bytes
// - Active-low receive reset holds path
`default_nettype none
package rcs_pkg;
	//==============================================================
	// Stream carriers
	typedef struct packed {
		logic [31:0] data;  // Frame bytes, first byte in lane 0
		logic [3:0]  keep;  // Lane qualifiers
		logic        valid; // Word present
		logic        sof;   // First preamble word
		logic        eof;   // Word holding last FCS byte
		logic        err;   // Line error code seen
	} rcs_rx_word_type;

	typedef struct packed {
		logic [31:0] tdata;
		logic [3:0]  tkeep;
		logic        tvalid;
		logic        tlast;
		logic        tuser;
	} rcs_axis_type;

	typedef struct packed {
		logic pause_hit; // Valid pause for us, consumed
		logic pfc_hit;   // Valid PFC frame, consumed
	} rcs_fc_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PRE  = 4'b0010,
		ST_BODY = 4'b0100,
		ST_TAIL = 4'b1000
	} rcs_state_type;

	//==============================================================
	// Register map
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_MTU      = 8'h04;
	localparam logic [7:0]  ADDR_GOOD     = 8'h08;
	localparam logic [7:0]  ADDR_BAD      = 8'h0C;
	localparam int          ADDR_W        = 8;
	localparam int          CTRL_FCS_PASS = 0;
	localparam int          CTRL_LEN_CHK  = 1;
	localparam int          CTRL_VLAN_LEN = 2;
	localparam int          CTRL_QINQ     = 3;
	localparam int          CTRL_JUMBO    = 4;
	localparam int          CTRL_MTU_EN   = 5;
	localparam int          CTRL_CTL_DIS  = 6;
	localparam int          CTRL_CUST_PRE = 7;
	localparam int          CTRL_FC_EN    = 8;
	localparam int          CTRL_PFC_EN   = 9;
	localparam logic [31:0] CTRL_MASK     = 32'h0000_03FF;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0002;
	localparam logic [31:0] MTU_MASK      = 32'h0000_FFFF;
	localparam logic [31:0] MTU_RESET     = 32'h0000_05EE;
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
	localparam logic [31:0] WORD_ONE      = 32'h0000_0001;
	localparam int          MTU_W         = 16;

	//==============================================================
	// Frame figures
	localparam logic [15:0] BYTES_ZERO     = 16'h0000;
	localparam logic [15:0] BYTES_MAX      = 16'hFFFF;
	localparam logic [15:0] MIN_FRAME      = 16'h0040;
	localparam logic [15:0] MAX_UNTAGGED   = 16'h05EE;
	localparam logic [15:0] MAX_TAGGED     = 16'h05F2;
	localparam logic [15:0] LEN_PAD_MIN    = 16'h002E;
	localparam logic [15:0] TYPE_MIN       = 16'h0600;
	localparam logic [15:0] TYPE_OFF_FIRST = 16'h000C;
	localparam logic [15:0] TYPE_BYTES     = 16'h0002;
	localparam logic [15:0] TAG_BYTES      = 16'h0004;
	localparam logic [15:0] FCS_BYTES      = 16'h0004;
	localparam logic [15:0] TPID_VLAN      = 16'h8100;
	localparam logic [15:0] TPID_QINQ      = 16'h88A8;
	localparam logic [15:0] TYPE_CONTROL   = 16'h8808;
	localparam logic [3:0]  TAGS_ZERO      = 4'h0;
	localparam logic [3:0]  TAGS_ONE       = 4'h1;
	localparam logic [3:0]  TAGS_QINQ      = 4'h8;
	localparam logic [3:0]  LANES_NONE     = 4'h0;
	localparam logic [3:0]  LANES_ALL      = 4'hF;
	localparam logic [3:0]  LANES_FIRST    = 4'h1;
	localparam int          LANES          = 4;
	localparam int          LANE_W         = 8;
	localparam logic [31:0] CRC_INIT       = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY       = 32'hEDB8_8320;
	localparam logic [31:0] CRC_RESIDUE    = 32'hDEBB_20E3;
	localparam rcs_axis_type BEAT_IDLE     = '0;
endpackage
`default_nettype wire

// file: rcs_rx_client_chk.sv
// Concurrent checks on the receive client stream and its register port
`default_nettype none
module rcs_rx_client_chk
	import rcs_pkg::*;
(
	input wire logic                     sys_clk_in,    // Clock
	input wire logic                     rst_in,        // Sync reset
	input wire logic                     rx_rst_n_in,   // Receive reset
	input wire rcs_pkg::rcs_rx_word_type rx_word_in,    // Receive words
	input wire rcs_pkg::rcs_axis_type    rx_axis_out,   // Client stream
	input wire logic                     hsel_in,       // Select
	input wire logic [31:0]              haddr_in,      // Address
	input wire logic [1:0]               htrans_in,     // Transfer
	input wire logic                     hwrite_in,     // Write
	input wire logic                     hreadyout_out, // Slave ready
	input wire logic                     hresp_out,     // Response
	input wire logic [31:0]              hrdata_out     // Read data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	//==============================================================
	// Frame end
	sequence s_eof_word;
		rx_rst_n_in && rx_word_in.valid && rx_word_in.eof;
	endsequence
	sequence s_last_beat;
		rx_axis_out.tvalid && rx_axis_out.tlast;
	endsequence
	// Status lags the last word by the pending stage
	AST_LAST_AFTER_EOF: assert property (s_eof_word |-> ##[1:3] s_last_beat)
		else $error("frame end missing after last word");
	AST_LAST_CAUSE: assert property (rx_axis_out.tlast |-> $past(rx_word_in.eof, 1)
		|| $past(rx_word_in.eof, 2) || $past(rx_word_in.eof, 3))
		else $error("frame end without a last word");
	AST_LAST_ONE: assert property (rx_axis_out.tlast |=> !rx_axis_out.tlast)
		else $error("frame end longer than one cycle");
	AST_LAST_BYTES: assert property (s_last_beat |-> rx_axis_out.tkeep != LANES_NONE)
		else $error("final beat without bytes");
	AST_STATUS_QUIET: assert property (rx_axis_out.tuser |-> s_last_beat)
		else $error("status outside frame end");
	//==============================================================
	// Lanes and reset
	AST_KEEP_SHAPE: assert property (rx_axis_out.tvalid |->
		rx_axis_out.tkeep inside {4'h1, 4'h3, 4'h7, 4'hF})
		else $error("lanes not filled from lane zero");
	AST_RX_HOLD: assert property (!rx_rst_n_in |=> rx_axis_out == BEAT_IDLE)
		else $error("stream active in receive reset");
	//==============================================================
	// Register port
	AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
		else $error("bus not ready or not okay");
	AST_CTRL_READ: assert property (hsel_in && htrans_in[1] && hreadyout_out && !hwrite_in
		&& haddr_in[7:0] == ADDR_CTRL |=> hrdata_out[31:10] == 22'h00_0000)
		else $error("unused control bits read back");
	AST_HOLE_READ: assert property (hsel_in && htrans_in[1] && hreadyout_out && !hwrite_in
		&& haddr_in[7:0] == 8'h10 |=> hrdata_out == WORD_ZERO)
		else $error("unmapped read not zero");
endmodule

bind rcs_rx_client rcs_rx_client_chk u_rcs_rx_client_chk (
	.sys_clk_in, .rst_in, .rx_rst_n_in, .rx_word_in, .rx_axis_out, .hsel_in, .haddr_in,
	.htrans_in, .hwrite_in, .hreadyout_out, .hresp_out, .hrdata_out
);
`default_nettype wire

// file: rcs_client_model.sv
// Client logic model that takes every beat of the received stream
`default_nettype none
module rcs_client_model
	import rcs_pkg::*;
(
	input  wire logic                  sys_clk_in,   // Clock
	input  wire logic                  clear_in,     // New frame
	input  wire rcs_pkg::rcs_axis_type rx_axis_in,   // Stream in
	output logic [15:0]                byte_cnt_out, // Bytes kept
	output logic                       done_out,     // Frame ended
	output logic                       good_out      // Frame status
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] byte_mem [0:2047];
	//==============================================================
	// Beat capture
	// never stalls
	// No ready, so a beat not stored at once is lost
	always @(posedge sys_clk_in)
	begin
		if (clear_in)
		begin
			byte_cnt_out <= 16'h0000;
			done_out     <= 1'b0;
			good_out     <= 1'b0;
		end
		else if (rx_axis_in.tvalid)
		begin
			for (int n = 0; n < LANES; n++)
				if (rx_axis_in.tkeep[n])
					byte_mem[int'(byte_cnt_out) + n] <= rx_axis_in.tdata[n*LANE_W +: LANE_W];
			byte_cnt_out <= byte_cnt_out + 16'($countones(rx_axis_in.tkeep));
			if (rx_axis_in.tlast)
			begin
				done_out <= 1'b1;
				good_out <= rx_axis_in.tuser;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the receive client stream block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rcs_pkg::*;
	typedef struct {
		logic [9:0]  ctrl;  // Control word
		logic [15:0] tpid;  // Tag type, zero if none
		logic [15:0] lt;    // Length or type
		int          total; // Bytes with FCS
		logic [3:0]  flaw;  // Pause, PFC, line error, FCS error
		logic        good;  // Status
		int          nb;    // Bytes delivered
	} rcs_case_type;
	logic            sys_clk_in = 1'b0;
	logic            rst_in = 1'b1;
	logic            rx_rst_n_in = 1'b1;
	logic            clear = 1'b1;
	rcs_rx_word_type rx_word = '0;
	rcs_fc_type      fc = '0;
	rcs_axis_type    rx_axis;
	logic            hsel = 1'b0;
	logic            hwrite = 1'b0;
	logic [1:0]      htrans = 2'b00;
	logic [31:0]     haddr = 32'h0000_0000;
	logic [31:0]     hwdata = 32'h0000_0000;
	logic            hready;
	logic            hresp;
	logic [31:0]     hrdata;
	logic [31:0]     rd;
	logic [15:0]     nbytes;
	logic            done;
	logic            good;
	logic [7:0]      fb [0:2047];
	int              errors = 0;
	int              samples_checked = 0;
	int              n_good = 0;
	int              n_bad = 0;
	// Ordinary frames; the MTU is set to 2000 first
	rcs_case_type cases [23] = '{
		'{10'h002, 16'h0, 16'h0800, 64, 4'h0, 1, 60}, '{10'h002, 16'h0, 16'h0010, 64, 4'h0, 1, 30},
		'{10'h002, 16'h0, 16'h0010, 68, 4'h0, 0, 30}, '{10'h002, 16'h0, 16'h0800, 64, 4'h1, 0, 60},
		'{10'h002, 16'h0, 16'h0800, 64, 4'h2, 0, 60}, '{10'h002, 16'h0, 16'h0800, 60, 4'h0, 0, 56},
		'{10'h002, 16'h0, 16'h0064, 64, 4'h0, 0, 60}, '{10'h002, 16'h0, 16'h002E, 64, 4'h0, 1, 60},
		'{10'h003, 16'h0, 16'h0010, 64, 4'h0, 1, 64}, '{10'h003, 16'h0, 16'h0800, 64, 4'h1, 0, 64},
		'{10'h002, 16'h0, 16'h0800, 1518, 4'h0, 1, 1514},
		'{10'h002, 16'h0, 16'h0800, 1519, 4'h0, 0, 1515},
		'{10'h012, 16'h0, 16'h0800, 1519, 4'h0, 1, 1515},
		'{10'h022, 16'h0, 16'h0800, 2000, 4'h0, 1, 1996},
		'{10'h022, 16'h0, 16'h0800, 2001, 4'h0, 0, 1997},
		'{10'h002, 16'h0, 16'h8808, 68, 4'h0, 0, 64}, '{10'h042, 16'h0, 16'h8808, 68, 4'h0, 1, 64},
		'{10'h082, 16'h0, 16'h0800, 64, 4'h0, 1, 68}, '{10'h102, 16'h0, 16'h8808, 64, 4'h8, 0, 60},
		'{10'h202, 16'h0, 16'h8808, 64, 4'h4, 0, 60},
		'{10'h002, 16'h8100, 16'h0010, 64, 4'h0, 1, 60},
		'{10'h006, 16'h8100, 16'h0010, 64, 4'h0, 1, 34},
		'{10'h00E, 16'h88A8, 16'h0010, 64, 4'h0, 1, 34}
	};
	initial
	begin
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	rcs_rx_client u_rcs_rx_client (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .rx_rst_n_in(rx_rst_n_in),
		.rx_word_in(rx_word), .fc_in(fc), .rx_axis_out(rx_axis), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
		.hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
		.hrdata_out(hrdata)
	);
	rcs_client_model u_rcs_client_model (
		.sys_clk_in(sys_clk_in), .clear_in(clear), .rx_axis_in(rx_axis),
		.byte_cnt_out(nbytes), .done_out(done), .good_out(good)
	);
	//==============================================================
	// Reporting
	task automatic test_done();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	//==============================================================
	// Register bus, single word transfers
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge sys_clk_in);
		while (hready !== 1'b1)
		begin
			k++;
			if (k > 50)
			begin
				errors++;
				test_done();
			end
			@(posedge sys_clk_in);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h00_0000, a};
		wait_rdy();
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		ahb(1'b0, a, WORD_ZERO);
		check(nm, exp, rd);
	endtask
	//==============================================================
	// Frames: two preamble words, then header, payload and FCS
	task automatic send(input rcs_case_type c, input int stop);
		logic [31:0] crc;
		int len, nw, k;
		len = c.total + 8;
		for (k = 0; k < len; k++)
			fb[k] = 8'(k * 37 + 5);
		{fb[20], fb[21]} = c.tpid != 16'h0000 ? c.tpid : c.lt;
		if (c.tpid != 16'h0000)
			{fb[24], fb[25]} = c.lt;
		crc = CRC_INIT;
		for (k = 8; k < len - 4; k++)
		begin
			crc ^= {24'h00_0000, fb[k]};
			repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
		end
		crc = ~crc ^ {31'h0000_0000, c.flaw[0]};
		for (k = 0; k < 4; k++)
			fb[len - 4 + k] = crc[k*8 +: 8];
		clear <= 1'b1;
		nw = (len + 3) / 4;
		for (k = 0; k < nw && k < stop; k++)
		begin
			@(posedge sys_clk_in);
			clear          <= 1'b0;
			rx_word.data   <= {fb[4*k+3], fb[4*k+2], fb[4*k+1], fb[4*k]};
			rx_word.keep   <= k == nw - 1 ? 4'((1 << (len - 4*k)) - 1) : LANES_ALL;
			rx_word.valid  <= 1'b1;
			rx_word.sof    <= k == 0;
			rx_word.eof    <= k == nw - 1;
			rx_word.err    <= c.flaw[1] && k == 5;
			fc             <= k == nw - 1 ? c.flaw[3:2] : 2'b00;
		end
		@(posedge sys_clk_in);
		rx_word <= '0;
		fc      <= '0;
	endtask
	task automatic finish_frame(input rcs_case_type c);
		int k, bad, off;
		for (k = 0; k < 20 && done !== 1'b1; k++)
			@(negedge sys_clk_in);
		if (done !== 1'b1)
		begin
			errors++;
			test_done();
		end
		check("status", {31'h0000_0000, c.good}, {31'h0000_0000, good});
		check("byte count", c.nb, {16'h0000, nbytes});
		bad = 0;
		off = c.ctrl[CTRL_CUST_PRE] ? 0 : 8;
		for (k = 0; k < c.nb; k++)
			if (u_rcs_client_model.byte_mem[k] !== fb[k + off])
				bad++;
		check("frame bytes", 0, bad);
		@(posedge sys_clk_in);
	endtask
	//==============================================================
	// Main sequence
	initial
	begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		reg_chk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
		reg_chk(ADDR_MTU, MTU_RESET, "mtu reset");
		ahb(1'b1, ADDR_GOOD, 32'h0000_FFFF);
		reg_chk(ADDR_GOOD, WORD_ZERO, "read-only count");
		ahb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
		reg_chk(ADDR_CTRL, CTRL_MASK, "ctrl bits");
		ahb(1'b1, ADDR_MTU, 32'h0000_07D0);
		reg_chk(8'h10, WORD_ZERO, "unmapped");
		reg_chk(ADDR_MTU, 32'h0000_07D0, "mtu");
		foreach (cases[i])
		begin
			ahb(1'b1, ADDR_CTRL, {22'h00_0000, cases[i].ctrl});
			send(cases[i], 4096);
			finish_frame(cases[i]);
			if (cases[i].good)
				n_good++;
			else
				n_bad++;
		end
		reg_chk(ADDR_GOOD, n_good, "good count");
		reg_chk(ADDR_BAD, n_bad, "bad count");
		// Receive reset in mid-frame drops the frame, then the path recovers
		send(cases[0], 8);
		rx_rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rx_rst_n_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		check("aborted frame end", 32'h0000_0000, {31'h0000_0000, done});
		send(cases[0], 4096);
		finish_frame(cases[0]);
		// Second full reset restores the control word
		rst_in <= 1'b1;
		@(posedge sys_clk_in);
		rst_in <= 1'b0;
		reg_chk(ADDR_CTRL, CTRL_RESET, "ctrl after reset");
		test_done();
	end
endmodule
`default_nettype wire
